// *** watchdog_pkg.sv ***
package watchdog_pkg;
	localparam logic [31:0] BLOCK_BASE = 32'h0000_0400;
	localparam logic [31:0] RELOAD_VALUE_OFS = 32'h0000_0000;
	localparam logic [31:0] WATCHDOG_CONTROL_OFS = 32'h0000_0004;
	localparam logic [31:0] KICK_STROBE_OFS = 32'h0000_0008;
	localparam logic [31:0] LIVE_COUNT_OFS = 32'h0000_000c;
	localparam int COUNT_W = 16;
	localparam logic [15:0] RELOAD_RESET = 16'h000f;
	localparam logic [15:0] LIVE_COUNT_RESET = 16'h000f;
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_EXPIRY_BIT = 1;
	localparam int CTL_HOLD_EN_LSB = 2;
	localparam int HOLD_W = 3;
	localparam logic [2:0] HOLD_EN_RESET = 3'h0;
	localparam logic CTL_ENABLE_RESET = 1'b0;
	localparam logic CTL_EXPIRY_RESET = 1'b0;
	localparam logic [5:0] TICKS_PER_COUNT = 6'h21;
endpackage : watchdog_pkg

// *** tick_prescaler.sv ***
// Counts rising edges of the slow tick pin and pulses once per full group.
module tick_prescaler (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_pin_i,
	input wire logic run_i,
	input wire logic restart_i,
	output logic step_o
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic [5:0] edges;
		logic step;
	} presc_state_t;

	presc_state_t state;
	presc_state_t next_state;

	always_comb begin
		next_state = state;
		next_state.sync1 = tick_pin_i;
		next_state.sync2 = state.sync1;
		next_state.prev = state.sync2;
		next_state.step = 1'b0;
		if (restart_i) begin
			next_state.edges = 6'h00;
		end else if (run_i && state.sync2 && !state.prev) begin
			if (state.edges == watchdog_pkg::TICKS_PER_COUNT - 6'h01) begin
				next_state.edges = 6'h00;
				next_state.step = 1'b1;
			end else begin
				next_state.edges = state.edges + 6'h01;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign step_o = state.step;
endmodule : tick_prescaler

// *** watchdog_register_block.sv ***
// Notes on behaviour
// - The register group sits at base 0000_0400h of the controller's 32-bit space, each register at its offset.
// - A 16-bit reload value resets to Fh and any write to it reloads the down-counter at once.
// - Control bits 4, 3 and 2 let hold inputs 2, 1 and 0 pause the counter, and all reset to zero.
// - Control bit 1 is set by hardware on a watchdog underflow, cleared by writing 1, and untouched by writing 0.
// - Control bit 0 enables the watchdog when 1 and resets to 0 so the watchdog starts inactive.
// - The 8-bit kick location is a write strobe without storage that always reads as zero.
// - While disabled, writes to the kick location are ignored.
// - The live 16-bit count is readable and resets to Fh.
// - The counter drops by one every 33 slow tick clock cycles, from the reload value down to zero.
// - On underflow a single-cycle watchdog event is emitted and the expiry flag is set.
// - Clearing the enable bit freezes the counter and stops its tick logic.
// - The power-on system reset returns every register and internal state to its default.
module watchdog_register_block (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] bus_addr_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [31:0] bus_wdata_i,
	output logic [31:0] bus_rdata_o,
	input wire logic slow_tick_clock_i,
	input wire logic [2:0] hold_input_bus_i,
	output logic watchdog_event_o,
	output logic watchdog_active_o
);
	typedef struct packed {
		logic [15:0] reload_value;
		logic [15:0] live_count;
		logic [2:0] hold_input_enable;
		logic expiry_reset_flag;
		logic enable;
		logic [2:0] hold_sync1;
		logic [2:0] hold_sync2;
		logic event_pulse;
		logic [31:0] rdata;
	} wdog_state_t;

	wdog_state_t state;
	wdog_state_t next_state;
	logic [31:0] offset;
	logic in_block;
	logic wr_reload;
	logic wr_control;
	logic wr_kick;
	logic holding;
	logic run;
	logic restart;
	logic step;

	assign in_block = (bus_addr_i[31:4] == watchdog_pkg::BLOCK_BASE[31:4]);
	assign offset = {28'h0000000, bus_addr_i[3:0]};
	assign wr_reload = bus_wr_i && in_block && (offset == watchdog_pkg::RELOAD_VALUE_OFS);
	assign wr_control = bus_wr_i && in_block && (offset == watchdog_pkg::WATCHDOG_CONTROL_OFS);
	assign wr_kick = bus_wr_i && in_block && (offset == watchdog_pkg::KICK_STROBE_OFS) && state.enable;

	assign holding = |(state.hold_sync2 & state.hold_input_enable);
	assign run = state.enable && !holding;
	assign restart = wr_reload || wr_kick;

	tick_prescaler i_tick_prescaler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_pin_i(slow_tick_clock_i),
		.run_i(run),
		.restart_i(restart),
		.step_o(step)
	);

	always_comb begin
		next_state = state;
		next_state.hold_sync1 = hold_input_bus_i;
		next_state.hold_sync2 = state.hold_sync1;
		next_state.event_pulse = 1'b0;

		if (wr_control) begin
			next_state.hold_input_enable = bus_wdata_i[watchdog_pkg::CTL_HOLD_EN_LSB +: watchdog_pkg::HOLD_W];
			next_state.enable = bus_wdata_i[watchdog_pkg::CTL_ENABLE_BIT];
			if (bus_wdata_i[watchdog_pkg::CTL_EXPIRY_BIT]) begin
				next_state.expiry_reset_flag = 1'b0;
			end
		end

		if (wr_reload) begin
			next_state.reload_value = bus_wdata_i[15:0];
			next_state.live_count = bus_wdata_i[15:0];
		end else if (wr_kick) begin
			next_state.live_count = state.reload_value;
		end else if (step && run) begin
			if (state.live_count == 16'h0000) begin
				next_state.event_pulse = 1'b1;
				next_state.expiry_reset_flag = 1'b1;
				next_state.live_count = state.reload_value;
			end else begin
				next_state.live_count = state.live_count - 16'h0001;
			end
		end

		next_state.rdata = 32'h0000_0000;
		if (bus_rd_i && in_block) begin
			case (offset)
				watchdog_pkg::RELOAD_VALUE_OFS: begin
					next_state.rdata = {16'h0000, state.reload_value};
				end
				watchdog_pkg::WATCHDOG_CONTROL_OFS: begin
					next_state.rdata = {27'h0000000, state.hold_input_enable, state.expiry_reset_flag, state.enable};
				end
				watchdog_pkg::KICK_STROBE_OFS: begin
					next_state.rdata = 32'h0000_0000;
				end
				watchdog_pkg::LIVE_COUNT_OFS: begin
					next_state.rdata = {16'h0000, state.live_count};
				end
				default: begin
					next_state.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= '0;
			state.reload_value <= watchdog_pkg::RELOAD_RESET;
			state.live_count <= watchdog_pkg::LIVE_COUNT_RESET;
			state.hold_input_enable <= watchdog_pkg::HOLD_EN_RESET;
			state.expiry_reset_flag <= watchdog_pkg::CTL_EXPIRY_RESET;
			state.enable <= watchdog_pkg::CTL_ENABLE_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign bus_rdata_o = state.rdata;
	assign watchdog_event_o = state.event_pulse;
	assign watchdog_active_o = state.enable;
endmodule : watchdog_register_block

// *** wdog_chk.sv ***
module wdog_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] bus_addr_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [31:0] bus_wdata_i,
	input wire logic [31:0] bus_rdata_o,
	input wire logic slow_tick_clock_i,
	input wire logic [2:0] hold_input_bus_i,
	input wire logic watchdog_event_o,
	input wire logic watchdog_active_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_load;
		bus_wr_i && bus_addr_i == 32'h0000_0400 ##2 bus_rd_i && bus_addr_i == 32'h0000_040c;
	endsequence
	a_reset_quiet: assert property ($fell(rst_i) |-> !watchdog_active_o && !watchdog_event_o)
		else $error("outputs not quiet after reset");
	a_event_single: assert property (watchdog_event_o |=> !watchdog_event_o)
		else $error("event longer than one cycle");
	a_idle_no_event: assert property (!watchdog_active_o [*3] |=> !watchdog_event_o)
		else $error("event while disabled");
	a_rdata_idle: assert property (!bus_rd_i |=> bus_rdata_o == 32'h0)
		else $error("read data not zero without read");
	a_unmapped_zero: assert property (bus_rd_i && bus_addr_i == 32'h0000_0500 |=> bus_rdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_kick_reads_zero: assert property (bus_rd_i && bus_addr_i == 32'h0000_0408 |=> bus_rdata_o == 32'h0)
		else $error("kick read not zero");
	a_ctl_reserved_zero: assert property (bus_rd_i && bus_addr_i == 32'h0000_0404 |=> bus_rdata_o[31:5] == 27'h0)
		else $error("control upper bits not zero");
	a_enable_follows: assert property (bus_wr_i && bus_addr_i == 32'h0000_0404 |=> watchdog_active_o == $past(bus_wdata_i[0]))
		else $error("active not following enable write");
	a_load_to_count: assert property (s_load |=> bus_rdata_o[15:0] == $past(bus_wdata_i[15:0], 3))
		else $error("count not reloaded by load write");
endmodule : wdog_chk

// *** tick_src.sv ***
module tick_src (
	input wire logic clk_i,
	input wire logic run_i,
	output logic tick_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] ph = 2'h0;
	// The tick stands low while the source is stopped.
	always @(posedge clk_i) begin
		ph <= run_i ? ph + 2'h1 : 2'h0;
	end
	assign tick_o = ph[1];
endmodule : tick_src

// *** tb_watchdog_register_block.sv ***
bind watchdog_register_block wdog_chk i_wdog_chk (.clk_i, .rst_i, .bus_addr_i, .bus_wr_i, .bus_rd_i, .bus_wdata_i,
	.bus_rdata_o, .slow_tick_clock_i, .hold_input_bus_i, .watchdog_event_o, .watchdog_active_o);
module tb_watchdog_register_block;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0, tick, ev, act;
	logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, d;
	logic [2:0] hold = 3'h0;
	int err_total = 0, n_checks = 0, cyc = 0, n;
	always #50 clk_i = ~clk_i;
	tick_src i_tick_src (.clk_i(clk_i), .run_i(run), .tick_o(tick));
	watchdog_register_block i_watchdog_register_block (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(addr),
		.bus_wr_i(wr), .bus_rd_i(rd), .bus_wdata_i(wdata), .bus_rdata_o(rdata), .slow_tick_clock_i(tick),
		.hold_input_bus_i(hold), .watchdog_event_o(ev), .watchdog_active_o(act));
	task finish_test;
		if (err_total == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wr_reg(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk_i) begin addr <= a; wdata <= v; wr <= 1'b1; end
		@(posedge clk_i) wr <= 1'b0;
	endtask : wr_reg
	task rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
		@(posedge clk_i) begin addr <= a; rd <= 1'b1; end
		@(posedge clk_i) rd <= 1'b0;
		#1 chk(nm, e, rdata);
	endtask : rd_chk
	task t_reset;
		rd_chk("reload", 32'h400, 32'hf);
		rd_chk("count", 32'h40c, 32'hf);
		rd_chk("control", 32'h404, 32'h0);
		rd_chk("kick", 32'h408, 32'h0);
		rd_chk("unmapped", 32'h500, 32'h0);
		wr_reg(32'h400, 32'h5);
		rd_chk("load", 32'h40c, 32'h5);
	endtask : t_reset
	task t_expire;
		wr_reg(32'h400, 32'h1);
		wr_reg(32'h404, 32'h1);
		run <= 1'b1;
		n = 0;
		while (ev !== 1'b1 && n < 2000) begin
			@(posedge clk_i);
			#1 n++;
		end
		chk("event", 32'h1, {31'h0, ev});
		chk("interval", 32'h1, {31'h0, n > 255 && n < 280});
		rd_chk("flag", 32'h404, 32'h3);
		rd_chk("reloaded", 32'h40c, 32'h1);
	endtask : t_expire
	task t_hold;
		@(posedge clk_i) hold <= 3'h1;
		wr_reg(32'h404, 32'h7);
		wr_reg(32'h400, 32'h2);
		repeat (400) @(posedge clk_i);
		rd_chk("held", 32'h40c, 32'h2);
		rd_chk("cleared", 32'h404, 32'h5);
		wr_reg(32'h404, 32'h0);
		hold <= 3'h0;
		repeat (300) @(posedge clk_i);
		rd_chk("frozen", 32'h40c, 32'h2);
	endtask : t_hold
	task t_kick;
		wr_reg(32'h404, 32'h1);
		repeat (150) @(posedge clk_i);
		wr_reg(32'h404, 32'h0);
		rd_chk("stepped", 32'h40c, 32'h1);
		chk("inactive", 32'h0, {31'h0, act});
		wr_reg(32'h408, 32'hff);
		rd_chk("kick_off", 32'h40c, 32'h1);
		wr_reg(32'h404, 32'h1);
		wr_reg(32'h408, 32'hff);
		rd_chk("kick_on", 32'h40c, 32'h2);
		chk("active", 32'h1, {31'h0, act});
		wr_reg(32'h404, 32'h0);
	endtask : t_kick
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			finish_test;
		end
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_expire;
		t_hold;
		t_kick;
		finish_test;
	end
endmodule : tb_watchdog_register_block
